/* design/bbx_exec.sv */
// Executor for branch-if-nonzero, relative jump and bit-set-in-file-register
`timescale 1ns/10ps
module bbx_exec (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Fetch stage
  input  wire logic [15:0]           instr_i,
  input  wire logic                  instr_valid_i,
  output logic                       instr_ack_o,
  // Core state
  input  wire logic                  zero_i,
  input  wire logic [bbx_pkg::PC_W-1:0]   pc_inc_i,
  input  wire logic [3:0]            bank_select_register_i,
  input  wire logic                  ext_en_i,
  input  wire logic [bbx_pkg::ADDR_W-1:0] index_base_i,
  // Program counter write
  output logic                       pc_we_o,
  output logic [bbx_pkg::PC_W-1:0]   program_counter_o,
  // Register file
  output logic                       reg_rd_o,
  output logic [bbx_pkg::ADDR_W-1:0] reg_addr_o,
  input  wire logic [7:0]            reg_rdata_i,
  output logic                       reg_we_o,
  output logic [7:0]                 reg_wdata_o,
  // Status
  output logic                       nop_cycle_o,
  output logic                       unhandled_o,
  output logic                       status_we_o
);
  import bbx_pkg::*;

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  bbx_phase_if ph_if ();

  bbx_phase_gen u_phase (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ph         (ph_if.src)
  );

  bbx_phase_t phase;
  assign phase = ph_if.phase;

  // ************************************************************
  // State
  // ************************************************************
  bbx_state_t             state_q,   state_d;
  bbx_op_t                op_q,      op_d;
  logic [10:0]            ofs_q,     ofs_d;
  logic [2:0]             bit_q,     bit_d;
  logic                   a_q,       a_d;
  logic [PC_W-1:0]        pcb_q,     pcb_d;
  logic                   taken_q,   taken_d;
  logic                   pc_we_q,   pc_we_d;
  logic [PC_W-1:0]        pc_q,      pc_d;
  logic                   rd_q,      rd_d;
  logic [ADDR_W-1:0]      addr_q,    addr_d;
  logic                   we_q,      we_d;
  logic [7:0]             wdata_q,   wdata_d;
  logic                   ack_d;
  logic                   unh_d,     unh_q;
  logic [ADDR_W-1:0]      ea;
  logic [PC_W-1:0]        rel;

  // Effective file address, resolved at decode
  always_comb begin
    if (instr_i[8]) begin
      ea = {bank_select_register_i, instr_i[7:0]};
    end else if (ext_en_i && (instr_i[7:0] <= IDX_MAX)) begin
      ea = index_base_i + {4'h0, instr_i[7:0]};
    end else if (instr_i[7:0] < ACC_SPLIT) begin
      ea = {ACC_LO_BANK, instr_i[7:0]};
    end else begin
      ea = {ACC_HI_BANK, instr_i[7:0]};
    end
  end

  // Doubled, sign-extended offset; the 8-bit case was widened at decode
  assign rel = {{(PC_W-12){ofs_q[10]}}, ofs_q, 1'b0};

  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    ofs_d   = ofs_q;
    bit_d   = bit_q;
    a_d     = a_q;
    pcb_d   = pcb_q;
    taken_d = taken_q;
    pc_we_d = 1'b0;
    pc_d    = pc_q;
    rd_d    = 1'b0;
    addr_d  = addr_q;
    we_d    = 1'b0;
    wdata_d = wdata_q;
    ack_d   = 1'b0;
    unh_d   = 1'b0;
    case (phase)
      BBX_Q1: begin
        op_d    = BBX_OP_NONE;
        taken_d = 1'b0;
        // The flushed cycle takes no word, so the fetched target waits
        if (state_q == BBX_RUN && instr_valid_i) begin
          ack_d = 1'b1;
          pcb_d = pc_inc_i;
          if (instr_i[15:8] == OPC_BRANCH_IF_NONZERO) begin
            op_d  = BBX_OP_BNZ;
            ofs_d = {{3{instr_i[7]}}, instr_i[7:0]};
          end else if (instr_i[15:12] == OPC_RELATIVE_JUMP) begin
            op_d  = BBX_OP_JMP;
            ofs_d = instr_i[10:0];
          end else if (instr_i[15:12] == OPC_BIT_SET_IN_FILE) begin
            op_d   = BBX_OP_BSF;
            bit_d  = instr_i[11:9];
            a_d    = instr_i[8];
            addr_d = ea;
            rd_d   = 1'b1;
          end else begin
            unh_d = 1'b1;
          end
        end
      end
      BBX_Q2: begin
        // Read data is sampled and modified in place
        if (op_q == BBX_OP_BSF) begin
          wdata_d = reg_rdata_i | (8'h01 << bit_q);
        end
      end
      BBX_Q3: begin
        if (op_q == BBX_OP_BNZ) begin
          taken_d = ~zero_i;
        end else if (op_q == BBX_OP_JMP) begin
          taken_d = 1'b1;
        end
        if ((op_q == BBX_OP_BNZ && !zero_i) || op_q == BBX_OP_JMP) begin
          pc_we_d = 1'b1;
          pc_d    = pcb_q + rel;
        end
        if (op_q == BBX_OP_BSF) begin
          we_d = 1'b1;
        end
      end
      default: begin
        // Q4 closes the cycle; a taken branch costs one flushed cycle
        if (taken_q) begin
          state_d = BBX_NOP;
        end else begin
          state_d = BBX_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= BBX_RUN;
      op_q    <= BBX_OP_NONE;
      ofs_q   <= 11'h000;
      bit_q   <= 3'h0;
      a_q     <= 1'b0;
      pcb_q   <= PC_RST;
      taken_q <= 1'b0;
      pc_we_q <= 1'b0;
      pc_q    <= PC_RST;
      rd_q    <= 1'b0;
      addr_q  <= ADDR_RST;
      we_q    <= 1'b0;
      wdata_q <= BYTE_RST;
      unh_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      ofs_q   <= ofs_d;
      bit_q   <= bit_d;
      a_q     <= a_d;
      pcb_q   <= pcb_d;
      taken_q <= taken_d;
      pc_we_q <= pc_we_d;
      pc_q    <= pc_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      we_q    <= we_d;
      wdata_q <= wdata_d;
      unh_q   <= unh_d;
    end
  end

  assign instr_ack_o       = ack_d;
  assign pc_we_o           = pc_we_q;
  assign program_counter_o = pc_q;
  assign reg_rd_o          = rd_q;
  assign reg_addr_o        = addr_q;
  assign reg_we_o          = we_q;
  assign reg_wdata_o       = wdata_q;
  assign nop_cycle_o       = (state_q == BBX_NOP);
  assign unhandled_o       = unh_q;
  assign status_we_o       = 1'b0;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_bnz_taken: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (phase == BBX_Q3 && op_q == BBX_OP_BNZ && !zero_i) |=> pc_we_o)
    else $error("branch-if-nonzero not taken with zero clear");

  a_bnz_skip: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (phase == BBX_Q3 && op_q == BBX_OP_BNZ && zero_i) |=> !pc_we_o ##1 !nop_cycle_o)
    else $error("branch-if-nonzero taken with zero set");

  a_target_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pc_we_o |-> program_counter_o == PC_W'(pcb_q + rel))
    else $error("branch target wrong");

  a_taken_nop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pc_we_o |=> nop_cycle_o[*4] ##1 !nop_cycle_o)
    else $error("taken branch not followed by exactly one no-op cycle");

  a_jump_always: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (phase == BBX_Q3 && op_q == BBX_OP_JMP) |=> pc_we_o)
    else $error("relative jump did not write program counter");

  a_bsf_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_we_o |-> (reg_wdata_o[bit_q] &&
      reg_wdata_o == ($past(reg_rdata_i, 2) | (8'h01 << bit_q))))
    else $error("bit-set write data wrong");

  a_bank_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_o && a_q) |-> reg_addr_o[11:8] == $past(bank_select_register_i))
    else $error("banked address not from bank select register");

  a_access_bank: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_o && !a_q && !$past(ext_en_i)) |->
      reg_addr_o[11:8] == ((reg_addr_o[7:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK))
    else $error("access bank address wrong");

  a_indexed_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_o && !a_q && $past(ext_en_i) && $past(instr_i[7:0]) <= IDX_MAX) |->
      reg_addr_o == ADDR_W'($past(index_base_i) + {4'h0, $past(instr_i[7:0])}))
    else $error("indexed literal offset address wrong");

  a_write_q4: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pc_we_o || reg_we_o) |-> (phase == BBX_Q4 && !status_we_o))
    else $error("write outside fourth phase");

endmodule : bbx_exec

/* design/bbx_phase_gen.sv */
// Four-phase sequencer: one phase per core clock, Q1 to Q4 in turn
`timescale 1ns/10ps
module bbx_phase_gen (
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   rst_i,
  // Phase out
  bbx_phase_if.src    ph
);
  import bbx_pkg::*;

  bbx_phase_t phase_q;
  bbx_phase_t phase_d;

  always_comb begin
    case (phase_q)
      BBX_Q1:  phase_d = BBX_Q2;
      BBX_Q2:  phase_d = BBX_Q3;
      BBX_Q3:  phase_d = BBX_Q4;
      default: phase_d = BBX_Q1;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= BBX_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign ph.phase = phase_q;

endmodule : bbx_phase_gen

/* inc/bbx_phase_if.sv */
// Interface: quadrature phase carried from the phase generator to the executor
`timescale 1ns/10ps
interface bbx_phase_if;
  import bbx_pkg::*;
  bbx_phase_t phase;
  modport src (output phase);
  modport snk (input phase);
endinterface : bbx_phase_if

/* inc/bbx_pkg.sv */
// Package: constants and types for the branch and bit-set execution block
package bbx_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PC_W   = 21;
  localparam int ADDR_W = 12;

  // ************************************************************
  // Opcode fields
  // ************************************************************
  localparam logic [7:0] OPC_BRANCH_IF_NONZERO = 8'hE1;
  localparam logic [3:0] OPC_RELATIVE_JUMP     = 4'hD;
  localparam logic [3:0] OPC_BIT_SET_IN_FILE   = 4'h8;

  // ************************************************************
  // Data memory mapping
  // ************************************************************
  localparam logic [7:0] ACC_SPLIT   = 8'h60;
  localparam logic [7:0] IDX_MAX     = 8'h5F;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [7:0]        BYTE_RST = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    BBX_Q1 = 4'b0001,
    BBX_Q2 = 4'b0010,
    BBX_Q3 = 4'b0100,
    BBX_Q4 = 4'b1000
  } bbx_phase_t;

  typedef enum logic [1:0] {
    BBX_RUN = 2'b01,
    BBX_NOP = 2'b10
  } bbx_state_t;

  typedef enum logic [3:0] {
    BBX_OP_NONE = 4'b0001,
    BBX_OP_BNZ  = 4'b0010,
    BBX_OP_JMP  = 4'b0100,
    BBX_OP_BSF  = 4'b1000
  } bbx_op_t;

endpackage : bbx_pkg

/* testbench/bbx_regfile_model.sv */
// Register file model facing the executor's read and write strobes
`timescale 1ns/10ps
module bbx_regfile_model (
  // Clock
  input  wire logic        core_clk_i,
  // Access strobes
  input  wire logic        rd_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  wdata_i,
  // Read data
  output logic [7:0]       rdata_o
);
  logic [7:0] mem_q [4096];
  logic [7:0] idle_q = 8'h5A;

  // Each byte starts as its own low address byte
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_q[i] = i[7:0];
    end
  end

  // Outside a read the bus toggles, so stale data never looks valid
  always @(posedge core_clk_i) begin
    idle_q <= ~idle_q;
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = rd_i ? mem_q[addr_i] : idle_q;
endmodule : bbx_regfile_model

/* testbench/tb_top.sv */
// Self-checking bench for the branch and bit-set executor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import bbx_pkg::*;
  typedef struct {
    logic [15:0] w; logic z; logic [20:0] pc; logic [3:0] bs; logic e; logic [11:0] ib;
    int k; logic [20:0] xpc; logic [11:0] xa; logic [7:0] xd;
  } bbx_row_t;
  logic core_clk_i = 1'b0;
  logic rst_i, instr_valid_i, instr_ack_o, zero_i, ext_en_i, pc_we_o, reg_rd_o, reg_we_o;
  logic nop_cycle_o, unhandled_o, status_we_o;
  logic [15:0] instr_i;
  logic [3:0] bank_select_register_i;
  logic [PC_W-1:0] pc_inc_i, program_counter_o;
  logic [ADDR_W-1:0] index_base_i, reg_addr_o;
  logic [7:0] reg_rdata_i, reg_wdata_o;
  int error_cnt = 0;
  int samples_checked = 0;
  bbx_row_t rows [12];

  always #12.5 core_clk_i = ~core_clk_i;

  bbx_exec dut_u (.core_clk_i, .rst_i, .instr_i, .instr_valid_i, .instr_ack_o, .zero_i,
    .pc_inc_i, .bank_select_register_i, .ext_en_i, .index_base_i, .pc_we_o,
    .program_counter_o, .reg_rd_o, .reg_addr_o, .reg_rdata_i, .reg_we_o, .reg_wdata_o,
    .nop_cycle_o, .unhandled_o, .status_we_o);

  bbx_regfile_model mdl_u (.core_clk_i, .rd_i(reg_rd_o), .addr_i(reg_addr_o),
    .we_i(reg_we_o), .wdata_i(reg_wdata_o), .rdata_o(reg_rdata_i));

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Present a row and wait, bounded, for the word to be taken
  task automatic apply(input int r);
    int k;
    @(negedge core_clk_i);
    instr_i = rows[r].w;
    zero_i = rows[r].z;
    pc_inc_i = rows[r].pc;
    bank_select_register_i = rows[r].bs;
    ext_en_i = rows[r].e;
    index_base_i = rows[r].ib;
    instr_valid_i = 1'b1;
    #1;
    for (k = 0; k < 16 && instr_ack_o !== 1'b1; k++) begin
      @(negedge core_clk_i);
    end
    if (k == 16) begin
      error_cnt++;
      final_report();
    end
  endtask : apply

  // Valid stays high through the window, so any ack in the flush is a fault
  task automatic exec(input int r);
    int tk, bs, n, pw_at, we_at;
    int pw = 0, we = 0, rd = 0, nop = 0, un = 0, ack = 0, st = 0;
    logic [PC_W-1:0] pcv;
    logic [ADDR_W-1:0] av;
    logic [7:0] dv;
    apply(r);
    tk = (rows[r].k == 1) ? 1 : 0;
    bs = (rows[r].k == 2) ? 1 : 0;
    pw_at = -1;
    we_at = -1;
    for (n = 0; n < 3 + 4 * tk; n++) begin
      @(negedge core_clk_i);
      if (pc_we_o === 1'b1) begin
        pw++;
        pw_at = n;
        pcv = program_counter_o;
      end
      if (reg_we_o === 1'b1) begin
        we++;
        we_at = n;
        av = reg_addr_o;
        dv = reg_wdata_o;
      end
      rd += (reg_rd_o === 1'b1 && n == 0);
      un += (unhandled_o === 1'b1 && n == 0);
      nop += (nop_cycle_o === 1'b1);
      ack += (instr_ack_o === 1'b1);
      st += (status_we_o === 1'b1);
    end
    `CHK("pc write", tk, pw)
    `CHK("pc write phase", tk ? 2 : -1, pw_at)
    if (tk == 1) `CHK("target", rows[r].xpc, pcv)
    `CHK("flush clocks", 4 * tk, nop)
    `CHK("ack in flush", 0, ack)
    `CHK("reg read", bs, rd)
    `CHK("reg write", bs, we)
    `CHK("reg write phase", bs ? 2 : -1, we_at)
    if (bs == 1) begin
      `CHK("reg addr", rows[r].xa, av)
      `CHK("reg data", rows[r].xd, dv)
    end
    `CHK("unhandled", (rows[r].k == 3) ? 1 : 0, un)
    `CHK("status write", 0, st)
  endtask : exec

  initial begin
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    zero_i = 1'b0;
    pc_inc_i = '0;
    bank_select_register_i = 4'h0;
    ext_en_i = 1'b0;
    index_base_i = '0;
    rows = '{
      '{16'hE17F, 0, 21'h000100, 4'h0, 0, 12'h000, 1, 21'h0001FE, 12'h000, 8'h00},
      '{16'hE180, 0, 21'h000400, 4'h0, 0, 12'h000, 1, 21'h000300, 12'h000, 8'h00},
      '{16'hE105, 1, 21'h000200, 4'h0, 0, 12'h000, 0, 21'h000000, 12'h000, 8'h00},
      '{16'hD3FF, 1, 21'h001000, 4'h0, 0, 12'h000, 1, 21'h0017FE, 12'h000, 8'h00},
      '{16'hD400, 0, 21'h001000, 4'h0, 0, 12'h000, 1, 21'h000800, 12'h000, 8'h00},
      '{16'hD7FF, 0, 21'h000000, 4'h0, 0, 12'h000, 1, 21'h1FFFFE, 12'h000, 8'h00},
      '{16'h8F0A, 0, 21'h000000, 4'h3, 0, 12'h000, 2, 21'h000000, 12'h30A, 8'h8A},
      '{16'h8020, 0, 21'h000000, 4'h3, 0, 12'h000, 2, 21'h000000, 12'h020, 8'h21},
      '{16'h8660, 0, 21'h000000, 4'h3, 1, 12'h123, 2, 21'h000000, 12'hF60, 8'h68},
      '{16'h8A5F, 0, 21'h000000, 4'h3, 1, 12'h123, 2, 21'h000000, 12'h182, 8'hA2},
      '{16'h8310, 0, 21'h000000, 4'hF, 1, 12'h123, 2, 21'h000000, 12'hF10, 8'h12},
      '{16'hE700, 0, 21'h000000, 4'h0, 0, 12'h000, 3, 21'h000000, 12'h000, 8'h00}};
    repeat (3) @(negedge core_clk_i);
    `CHK("reset outputs", 4'h0, {pc_we_o, reg_we_o, nop_cycle_o, unhandled_o})
    rst_i = 1'b0;
    for (int i = 0; i < 12; i++) begin
      exec(i);
    end
    // ************************************************************
    // Reset in the middle of a flush
    // ************************************************************
    apply(3);
    repeat (5) @(negedge core_clk_i);
    `CHK("flush mid", 1'b1, nop_cycle_o)
    // Valid drops with reset, else the held jump is taken again at release
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    #1;
    `CHK("flush cut", 3'h0, {pc_we_o, nop_cycle_o, reg_we_o})
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (2) begin
      @(negedge core_clk_i);
      `CHK("after reset", 3'h0, {pc_we_o, reg_rd_o, nop_cycle_o})
    end
    exec(6);
    exec(0);
    final_report();
  end
endmodule : tb_top
